// File: interface_strap_and_reset_select_tb.sv
// Self-checking bench for isr_top with a host reset source.
// Assumes every output registers one edge after its inputs.
`timescale 1ns/1ps
`default_nettype none
module interface_strap_and_reset_select_tb;
  logic clk = 1'b0, rst_b = 1'b0, serial_mode_strap = 1'b1, bus_style_strap = 1'b1;
  logic clk_neg_pin = 1'b1, clk_en = 1'b1, i2c_run = 1'b1, scl_in = 1'b1, go = 1'b0;
  logic s_cap, b_cap, c_cap;
  logic [4:0] len = 5'h00;
  logic [29:0] rin = 30'h0;
  logic [17:0] exp_q[$];
  logic [17:0] got;
  int seed = 14, fails = 0, check_count = 0;
  wire logic [7:0] modem_control_reg, enhanced_feature_reg;
  wire logic factory_test_sel_2, factory_test_sel_1, factory_test_sel_0, uart_tx_data;
  wire logic uart_tx_req, rx_pin, clear_to_send_n, data_set_ready_n, carrier_detect_n;
  wire logic ring_indicator_n, transceiver_irq_n, transceiver_data_in, radio_data_lines_enable;
  wire logic radio_tx_bit, reset_pin;
  logic serial_if_en, parallel_if_en, split_strobe_mode, dev_reset, tx_pin, rx_data, tx_allowed;
  logic request_to_send_n, transceiver_reset, transceiver_irq, transceiver_data_out;
  logic radio_rx_bit, radio_over_i2c, scl_out, scl_oe, single_ended_clk, factory_test;
  logic [3:0] gp_inputs;
  isr_pkg::isr_state_type state;
  assign {modem_control_reg, enhanced_feature_reg, factory_test_sel_2, factory_test_sel_1,
    factory_test_sel_0, uart_tx_data, uart_tx_req, rx_pin, clear_to_send_n, data_set_ready_n,
    carrier_detect_n, ring_indicator_n, transceiver_irq_n, transceiver_data_in,
    radio_data_lines_enable, radio_tx_bit} = rin;
  isr_top uut (.*);
  isr_host_model host (.clk(clk), .active_high(bus_style_strap), .go(go), .len(len),
    .reset_pin(reset_pin));
  always #2 clk = ~clk;
  task automatic stop_test();
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One note per cycle when chk is set; h says whether the device is expected in reset
  task automatic step(input bit h, input bit chk);
    logic [31:0] r;
    @(negedge clk);
    go <= 1'b0;
    r = $random(seed);
    rin = r[29:0];
    rin[20] = rin[20] & rin[23];
    if (h)
      {s_cap, b_cap, c_cap} = {serial_mode_strap, bus_style_strap, clk_neg_pin};
    #1;
    if (chk)
      exp_q.push_back(h ? {s_cap, !s_cap, b_cap, 5'h1d, 4'hf, 4'h9, c_cap, 1'b0}
        : {s_cap, !s_cap, b_cap, 1'b0, uart_tx_req ? uart_tx_data : 1'b1, rx_pin,
        !(enhanced_feature_reg[7] & clear_to_send_n), !modem_control_reg[1], clear_to_send_n,
        data_set_ready_n, carrier_detect_n, ring_indicator_n, 1'b0, !transceiver_irq_n,
        radio_data_lines_enable & radio_tx_bit, !radio_data_lines_enable, c_cap,
        factory_test_sel_2 | factory_test_sel_1 | factory_test_sel_0});
  endtask
  always @(posedge clk)
  begin
    #1;
    if (exp_q.size() != 0)
    begin
      got = {serial_if_en, parallel_if_en, split_strobe_mode, dev_reset, tx_pin, rx_data,
        tx_allowed, request_to_send_n, gp_inputs, transceiver_reset, transceiver_irq,
        transceiver_data_out, radio_over_i2c, single_ended_clk, factory_test};
      check_count++;
      if (got !== exp_q[0])
      begin
        fails++;
        $display("BAD %0t got %h want %h", $time, got, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end
  initial
  begin
    repeat (6) step(1'b1, 1'b1);
    @(negedge clk) rst_b = 1'b1;
    repeat (800) step(1'b0, 1'b1);
    len = 5'h09;
    go = 1'b1;
    repeat (14) step(1'b0, 1'b1);
    len = 5'h10;
    go = 1'b1;
    repeat (12) step(1'b0, 1'b0);
    repeat (3) step(1'b1, 1'b1);
    repeat (4) step(1'b0, 1'b0);
    @(negedge clk);
    serial_mode_strap = 1'b0;
    clk_neg_pin = 1'b0;
    repeat (20) step(1'b0, 1'b1);
    @(negedge clk);
    bus_style_strap = 1'b0;
    rst_b = 1'b0;
    repeat (6) step(1'b1, 1'b1);
    @(negedge clk) rst_b = 1'b1;
    repeat (20) step(1'b0, 1'b1);
    len = 5'h10;
    go = 1'b1;
    repeat (12) step(1'b0, 1'b0);
    repeat (3) step(1'b1, 1'b1);
    repeat (4) step(1'b0, 1'b0);
    repeat (10) step(1'b0, 1'b1);
    repeat (2) @(negedge clk);
    stop_test();
  end
endmodule
`default_nettype wire

// File: isr_host_model.sv
// Host side source of reset pin pulses.
// Assumes go and len are set off the falling edge.
`timescale 1ns/1ps
`default_nettype none
module isr_host_model
(
  input wire logic       clk,
  input wire logic       active_high,
  input wire logic       go,
  input wire logic [4:0] len,
  output logic           reset_pin
);
  logic [4:0] left_reg = 5'h00;
  // Short pulses are sent only when the bench asks for them
  always @(negedge clk)
    left_reg <= go ? len : (left_reg != 5'h00 ? left_reg - 5'h01 : 5'h00);
  assign reset_pin = (left_reg != 5'h00) ? active_high : !active_high;
endmodule
`default_nettype wire

// File: isr_monitor.sv
// Port checker for isr_top.
// Assumes clk_en is held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module isr_monitor
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       bus_style_strap,
  input wire logic       reset_pin,
  input wire logic [7:0] enhanced_feature_reg,
  input wire logic       clear_to_send_n,
  input wire logic       transceiver_irq_n,
  input wire logic       radio_data_lines_enable,
  input wire logic       i2c_run,
  input wire logic       dev_reset,
  input wire logic       tx_pin,
  input wire logic       rx_data,
  input wire logic       tx_allowed,
  input wire logic [3:0] gp_inputs,
  input wire logic       transceiver_irq,
  input wire logic       radio_over_i2c,
  input wire logic       scl_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [9:0] gap_reg;
  logic       armed_reg;
  logic [3:0] active_run_reg;
  // Counts active pin samples; a long repetition would be unrolled by the tools
  always_ff @(posedge clk)
    if (!rst_b || reset_pin != bus_style_strap)
      active_run_reg <= 4'h0;
    else if (active_run_reg != 4'h9)
      active_run_reg <= active_run_reg + 4'h1;
  // Armed only after a toggle while running, so a restart is not judged
  always_ff @(posedge clk)
    if (!rst_b || dev_reset || !i2c_run)
      armed_reg <= 1'b0;
    else if ($changed(scl_oe))
      armed_reg <= 1'b1;
  always_ff @(posedge clk)
    gap_reg <= $changed(scl_oe) ? 10'h000 : gap_reg + 10'h001;
  a_tx_held_high: assert property (dev_reset |-> tx_pin && rx_data)
    else $error("tx or rx not held in reset");
  a_reset_outs: assert property (dev_reset |-> gp_inputs == 4'hf && !tx_allowed)
    else $error("outputs not in reset state");
  a_pin_qualify: assert property (reset_pin == bus_style_strap && active_run_reg == 4'h9 |-> ##[0:2] dev_reset)
    else $error("long reset pulse not taken");
  a_radio_route: assert property (!dev_reset |-> radio_over_i2c == !$past(radio_data_lines_enable))
    else $error("radio path select wrong");
  a_cts_gate: assert property (!dev_reset && $past(enhanced_feature_reg[7]) && $past(clear_to_send_n)
    |-> !tx_allowed)
    else $error("transmit not stopped by clear to send");
  a_cts_gp_in: assert property (!dev_reset |-> gp_inputs[3] == $past(clear_to_send_n))
    else $error("clear to send not seen as input");
  a_irq_map: assert property (!dev_reset |-> transceiver_irq == !$past(transceiver_irq_n))
    else $error("transceiver interrupt not taken");
  a_scl_half_rate: assert property (armed_reg && $changed(scl_oe) |-> gap_reg == 10'h138)
    else $error("serial clock half period wrong");
  c_pin_reset: cover property (dev_reset && rst_b);
  c_scl_toggle: cover property (armed_reg && $changed(scl_oe));
  c_radio_lines: cover property (!dev_reset && !radio_over_i2c);
endmodule
bind isr_top isr_monitor u_mon (.*);
`default_nettype wire

// File: isr_pkg.sv
// Constants for the interface strap and reset select block.
// Assumes a single 250 MHz clock domain.
package isr_pkg;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned RST_MIN_PULSE_PS = 40000;
  // Least time rounds up
  localparam int unsigned RST_MIN_CYC =
    (RST_MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned SCL_MAX_HZ       = 400000;
  localparam int unsigned CLK_HZ           = 250000000;
  // Half period count, rounded up so the rate never exceeds the maximum
  localparam int unsigned SCL_HALF_CYC =
    (CLK_HZ + 2 * SCL_MAX_HZ - 1) / (2 * SCL_MAX_HZ);
  localparam int unsigned SCL_CNT_W        = 10;
  localparam int unsigned RST_CNT_W        = 4;
  localparam int unsigned MCR_RTS_BIT      = 1;
  localparam int unsigned EFR_AUTO_CTS_BIT = 7;
  localparam int unsigned EFR_AUTO_RTS_BIT = 6;
  localparam logic [7:0]  MODEM_CTRL_RST   = 8'h00;
  localparam logic [7:0]  ENH_FEAT_RST     = 8'h00;
  localparam logic [3:0]  GPI_RST          = 4'hf;
  typedef enum logic [1:0] {ISR_RUN, ISR_RESET_HOLD, ISR_TEST} isr_state_type;
endpackage

// File: isr_pulse_filter.sv
// Qualifies the decoded reset level against a minimum length.
// Assumes the level is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module isr_pulse_filter
  import isr_pkg::*;
(
  input  wire logic clk,
  input  wire logic clk_en,
  input  wire logic level_in,
  output logic      qualified
);
  logic [RST_CNT_W-1:0] count_reg;

  always_ff @(posedge clk)
  begin
    if (clk_en)
    begin
      if (!level_in)
        count_reg <= '0;
      else if (count_reg != RST_CNT_W'(RST_MIN_CYC))
        count_reg <= count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en)
      qualified <= level_in && (count_reg == RST_CNT_W'(RST_MIN_CYC - 1) ||
                                count_reg == RST_CNT_W'(RST_MIN_CYC));
  end
endmodule
`default_nettype wire

// File: isr_scl_gen.sv
// Serial clock divider toward the transceiver.
// Assumes run is synchronous; clock idles high when stopped.
`timescale 1ns/1ps
`default_nettype none
module isr_scl_gen
  import isr_pkg::*;
(
  input  wire logic clk,
  input  wire logic clk_en,
  input  wire logic rst_b,
  input  wire logic run,
  output logic      scl_low
);
  logic [SCL_CNT_W-1:0] div_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_reg <= '0;
      scl_low <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        div_reg <= '0;
        scl_low <= 1'b0;
      end
      else if (div_reg == SCL_CNT_W'(SCL_HALF_CYC - 1))
      begin
        div_reg <= '0;
        scl_low <= ~scl_low;
      end
      else
        div_reg <= div_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: isr_top.sv
// Strap decode, reset select and side-band pin roles of the UART controller.
// Assumes all pins are synchronous to clk; straps are static.
//
// Operation
// [RL1] Serial host interface is on when the mode strap is high, parallel when low.
// [RL2] Bus style strap high selects read and write strobes, low selects direction and select.
// [RL3] Reset input is active high under bus style high and active low otherwise.
// [RL4] A reset held at least 40 ns clears all registers and puts outputs in reset state.
// [RL5] During reset the transmit output stays high and receive is ignored.
// [RL6] The controller asserts request-to-send before enabling automatic flow control.
// [RL7] Clear-to-send is a general input or gates transmit when its feature bit is set.
// [RL8] Data-set-ready, carrier-detect and ring-indicator never affect the UART.
// [RL9] Transceiver data uses the dedicated lines only while their enable is high, else I2C.
// [RL10] Clock comes from a differential pair, single ended when the negative input is high.
// [RL11] Any of the three test inputs high enters factory test, all low is normal.
// [RL12] A reset output drives the transceiver and its active-low interrupt is accepted.
// [RL13] The serial clock toward the transceiver stays at or below 400 kHz.
// [RL14] Mode and bus style straps are captured at reset and then held; reset input polarity follows the live bus style strap.
`timescale 1ns/1ps
`default_nettype none
module isr_top
  import isr_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       serial_mode_strap,
  input  wire logic       bus_style_strap,
  input  wire logic       reset_pin,
  input  wire logic       clk_neg_pin,
  input  wire logic       factory_test_sel_2,
  input  wire logic       factory_test_sel_1,
  input  wire logic       factory_test_sel_0,
  input  wire logic [7:0] modem_control_reg,
  input  wire logic [7:0] enhanced_feature_reg,
  input  wire logic       uart_tx_data,
  input  wire logic       uart_tx_req,
  input  wire logic       rx_pin,
  input  wire logic       clear_to_send_n,
  input  wire logic       data_set_ready_n,
  input  wire logic       carrier_detect_n,
  input  wire logic       ring_indicator_n,
  input  wire logic       transceiver_irq_n,
  input  wire logic       transceiver_data_in,
  input  wire logic       radio_data_lines_enable,
  input  wire logic       radio_tx_bit,
  input  wire logic       i2c_run,
  input  wire logic       scl_in,
  output logic            serial_if_en,
  output logic            parallel_if_en,
  output logic            split_strobe_mode,
  output logic            dev_reset,
  output logic            tx_pin,
  output logic            rx_data,
  output logic            tx_allowed,
  output logic            request_to_send_n,
  output logic [3:0]      gp_inputs,
  output logic            transceiver_reset,
  output logic            transceiver_irq,
  output logic            transceiver_data_out,
  output logic            radio_rx_bit,
  output logic            radio_over_i2c,
  output logic            scl_out,
  output logic            scl_oe,
  output logic            single_ended_clk,
  output logic            factory_test,
  output isr_state_type   state
);
  logic style_reg;
  logic reset_level;
  logic reset_qual;
  logic hold_reset;
  logic scl_low;
  logic test_any;

  // Polarity follows the live strap pin, not the value captured at reset
  assign reset_level = bus_style_strap ? reset_pin : ~reset_pin; // see [RL3]
  assign test_any = factory_test_sel_2 | factory_test_sel_1 | factory_test_sel_0;
  assign hold_reset = reset_qual | ~rst_b;

  isr_pulse_filter u_filter
  (
    .clk       (clk),
    .clk_en    (clk_en),
    .level_in  (reset_level),
    .qualified (reset_qual)
  );

  isr_scl_gen u_scl
  (
    .clk     (clk),
    .clk_en  (clk_en),
    .rst_b   (~hold_reset),
    .run     (i2c_run),
    .scl_low (scl_low)
  );

  // Straps sampled only while reset is held, so a later change is ignored
  always_ff @(posedge clk)
  begin
    if (clk_en && hold_reset)
    begin
      style_reg         <= bus_style_strap; // see [RL14]
      serial_if_en      <= serial_mode_strap; // see [RL1]
      parallel_if_en    <= ~serial_mode_strap; // see [RL1]
      split_strobe_mode <= bus_style_strap; // see [RL2]
      single_ended_clk  <= clk_neg_pin; // see [RL10]
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en)
      dev_reset <= hold_reset; // see [RL4]
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state <= ISR_RESET_HOLD;
    else if (clk_en)
    begin
      case (state)
        ISR_RUN:
          if (reset_qual)
            state <= ISR_RESET_HOLD;
          else if (test_any)
            state <= ISR_TEST; // see [RL11]
        ISR_RESET_HOLD:
          if (!reset_qual)
            state <= test_any ? ISR_TEST : ISR_RUN;
        ISR_TEST:
          if (reset_qual)
            state <= ISR_RESET_HOLD;
          else if (!test_any)
            state <= ISR_RUN; // see [RL11]
        default:
          state <= ISR_RESET_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en)
      factory_test <= test_any && !hold_reset; // see [RL11]
  end

  // UART line side
  always_ff @(posedge clk)
  begin
    if (hold_reset)
    begin
      tx_pin            <= 1'b1; // see [RL5]
      rx_data           <= 1'b1; // see [RL5]
      tx_allowed        <= 1'b0;
      request_to_send_n <= 1'b1; // see [RL4]
    end
    else if (clk_en)
    begin
      tx_pin            <= uart_tx_req ? uart_tx_data : 1'b1;
      rx_data           <= rx_pin;
      // Auto flow only gates; the controller must already assert send request
      tx_allowed        <= ~enhanced_feature_reg[EFR_AUTO_CTS_BIT] |
                           ~clear_to_send_n; // see [RL7]
      request_to_send_n <= ~modem_control_reg[MCR_RTS_BIT]; // see [RL6]
    end
  end

  // Modem status lines are readable; only clear-to-send also steers the UART
  always_ff @(posedge clk)
  begin
    if (hold_reset)
      gp_inputs <= GPI_RST;
    else if (clk_en)
      gp_inputs <= {clear_to_send_n, data_set_ready_n,
                    carrier_detect_n, ring_indicator_n}; // see [RL8]
  end

  // Transceiver side band
  always_ff @(posedge clk)
  begin
    if (hold_reset)
    begin
      transceiver_reset    <= 1'b1; // see [RL12]
      transceiver_irq      <= 1'b0;
      transceiver_data_out <= 1'b0;
      radio_rx_bit         <= 1'b0;
      radio_over_i2c       <= 1'b1;
    end
    else if (clk_en)
    begin
      transceiver_reset    <= 1'b0;
      transceiver_irq      <= ~transceiver_irq_n; // see [RL12]
      transceiver_data_out <= radio_data_lines_enable & radio_tx_bit; // see [RL9]
      radio_rx_bit         <= radio_data_lines_enable & transceiver_data_in; // see [RL9]
      radio_over_i2c       <= ~radio_data_lines_enable; // see [RL9]
    end
  end

  // Open drain clock: drive low only, release for high
  always_ff @(posedge clk)
  begin
    if (hold_reset)
    begin
      scl_out <= 1'b0;
      scl_oe  <= 1'b0;
    end
    else if (clk_en)
    begin
      scl_out <= 1'b0;
      scl_oe  <= scl_low; // see [RL13]
    end
  end
endmodule
`default_nettype wire
